/* rtl/taf_framer.sv */
`timescale 1ns/100ps
// Overview of operation
// - each data telegram carries 32-bit signature
// - signature is CCM over nonce, payload, key
// - nonce: address, counter, three zero bytes
// - address and counter least significant first
// - sign length, type, vendor, counter, event
// - signature follows the event byte
// - sign with factory key unless alternate key selected
// - commissioning payload 30 bytes, 0x1D, 0xFF
// - vendor, counter, key, address follow type
// - counter from zero, plus one per telegram
// - vendor identifier configurable, default at reset
// - zgp format when configuration selects it
// - zgp sends requested decommissioning telegram
// - commission on learn or pending request
// - learn held: only first direction commissions
// - pending request served once, then cleared
// - otherwise every actuation seen while idle sends data
// - data payload 13 bytes, tag last
module taf_framer
   import taf_pkg::*;
#(
   parameter logic [15:0] VENDOR_RESET = 16'h0F0F  // arbitrary default value
) (
   input  wire logic                 CLOCK,            // 250 MHz system clock
   input  wire logic                 RST,              // async reset, active high
   input  wire logic [4:0]           AVS_ADDRESS,      // avalon byte address
   input  wire logic                 AVS_READ,         // avalon read
   input  wire logic                 AVS_WRITE,        // avalon write
   input  wire logic [31:0]          AVS_WRITEDATA,    // avalon write data
   input  wire logic [3:0]           AVS_BYTEENABLE,   // avalon byte enables
   output      logic [31:0]          AVS_READDATA,     // avalon read data
   output      logic                 AVS_WAITREQUEST,  // avalon wait
   input  wire logic                 ACTUATE_PIN,      // harvester energy pulse
   input  wire logic                 DIRECTION_PIN,    // 1 push, 0 pull
   input  wire logic                 LEARN_BUTTON_PIN, // learn button held
   input  wire logic [7:0]           EVENT_PIN,        // button event byte
   input  wire logic [127:0]         FACTORY_KEY,      // factory key
   input  wire logic [127:0]         ALTERNATE_KEY,    // alternate key
   input  wire logic [47:0]          SOURCE_ADDR,      // static source address
   output      logic                 AES_REQ,          // block cipher request
   output      logic [127:0]         AES_KEY,          // cipher key
   output      logic [127:0]         AES_IN,           // plaintext block
   input  wire logic                 AES_DONE,         // cipher result pulse
   input  wire logic [127:0]         AES_OUT,          // ciphertext block
   output      taf_pkg::taf_beat_s   TX_BEAT,          // payload byte stream
   output      logic                 TX_VALID,         // beat valid
   input  wire logic                 TX_READY,         // radio accepts beat
   output      logic                 TX_ZGP            // telegram in zgp format
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_MAC0, ST_MAC1, ST_MAC2,
                             ST_FILL, ST_LOAD, ST_SHOW} taf_state_e;
   taf_state_e   state_q;        // sequencer state
   taf_kind_e    kind_q;         // telegram in progress
   taf_ctrl_s    ctrl_q;         // control register
   logic [15:0]  vendor_q;       // vendor identifier
   logic         comm_req_q;     // pending commissioning request
   logic         decom_req_q;    // pending decommissioning request
   logic [31:0]  counter_q;      // telegram counter
   logic         lrn_lat_q;      // learn direction latched
   logic         lrn_dir_q;      // latched direction
   logic [10:0]  sync1_q;        // first synchroniser stage
   logic [10:0]  sync2_q;        // second synchroniser stage
   logic         act_prev_q;     // actuation edge history
   logic [7:0]   event_q;        // event byte of this telegram
   logic [127:0] x1_q;           // cbc-mac chain value
   logic [31:0]  tag_q;          // mac before masking
   logic [31:0]  sig_q;          // transmitted signature
   logic [4:0]   idx_q;          // payload byte index
   logic         ack_q;          // bus answer phase
   logic [103:0] nonce;          // ccm nonce
   logic         act_rise;       // actuation event
   logic         act_dir;        // synchronised direction
   logic         act_lrn;        // synchronised learn button
   logic         start;          // a telegram is chosen
   taf_kind_e    pick;           // chosen kind
   logic         take_comm;      // commission request consumed
   logic         take_decom;     // decommission request consumed
   logic         done;           // final beat accepted
   logic         wr_hit;         // accepted bus write
   logic [4:0]   last_idx;       // index of final byte
   logic [7:0]   fill_byte;      // byte written to buffer
   logic [7:0]   ram_rd;         // buffered byte

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // two flops before any logic looks at a pin
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         act_prev_q <= 1'b0;
      end else begin
         sync1_q    <= {ACTUATE_PIN, DIRECTION_PIN, LEARN_BUTTON_PIN, EVENT_PIN};
         sync2_q    <= sync1_q;
         act_prev_q <= sync2_q[10];
      end
   end
   assign act_rise = sync2_q[10] & ~act_prev_q;
   assign act_dir  = sync2_q[9];
   assign act_lrn  = sync2_q[8];

   // ---------------------------------------------------------------
   // telegram choice
   // ---------------------------------------------------------------
   // in zgp mode decommission wins, then pending request, then learn, then data
   always_comb begin
      start      = 1'b0;
      pick       = KIND_DATA;
      take_comm  = 1'b0;
      take_decom = 1'b0;
      if (act_rise && state_q == ST_IDLE) begin
         start = 1'b1;
         if (ctrl_q.zgp_mode && decom_req_q) begin
            pick       = KIND_DECOM;
            take_decom = 1'b1;
         end else if (comm_req_q) begin
            pick      = KIND_COMM;
            take_comm = 1'b1;
         end else if (act_lrn) begin
            pick  = KIND_COMM;
            start = !lrn_lat_q || (act_dir == lrn_dir_q);
         end else begin
            pick = KIND_DATA;
         end
      end
   end

   // learn direction latch, dropped when the button is let go
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         lrn_lat_q <= 1'b0;
         lrn_dir_q <= 1'b0;
      end else if (!act_lrn) begin
         lrn_lat_q <= 1'b0;
      end else if (start && pick == KIND_COMM && !take_comm && !lrn_lat_q) begin
         lrn_lat_q <= 1'b1;
         lrn_dir_q <= act_dir;
      end
   end

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
   assign wr_hit          = AVS_WRITE & ack_q;

   // answer one cycle after the request is seen
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
      end
   end

   // read data captured while waitrequest is high
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ && !ack_q) begin
         unique case (AVS_ADDRESS)
            REG_CTRL:    AVS_READDATA <= {30'h0, ctrl_q.alt_key, ctrl_q.zgp_mode};
            REG_VENDOR:  AVS_READDATA <= {16'h0000, vendor_q};
            REG_REQUEST: AVS_READDATA <= {30'h0, decom_req_q, comm_req_q};
            REG_COUNTER: AVS_READDATA <= counter_q;
            REG_STATUS:  AVS_READDATA <= {27'h0, lrn_dir_q, lrn_lat_q, kind_q,
                                          state_q != ST_IDLE};
            default:     AVS_READDATA <= 32'h0000_0000;  // unmapped
         endcase
      end
   end

   // control and vendor registers
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl_q   <= '0;
         vendor_q <= VENDOR_RESET;
      end else if (wr_hit) begin
         if (AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0]) begin
            ctrl_q.zgp_mode <= AVS_WRITEDATA[CTRL_ZGP_BIT];
            ctrl_q.alt_key  <= AVS_WRITEDATA[CTRL_ALT_BIT];
         end
         if (AVS_ADDRESS == REG_VENDOR) begin
            if (AVS_BYTEENABLE[0]) vendor_q[7:0]  <= AVS_WRITEDATA[7:0];
            if (AVS_BYTEENABLE[1]) vendor_q[15:8] <= AVS_WRITEDATA[15:8];
         end
      end
   end

   // request flags: a software set beats a hardware clear
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         comm_req_q  <= 1'b0;
         decom_req_q <= 1'b0;
      end else begin
         comm_req_q  <= (comm_req_q & ~take_comm) |
                        (wr_hit && AVS_ADDRESS == REG_REQUEST && AVS_BYTEENABLE[0] &&
                         AVS_WRITEDATA[REQ_COMM_BIT]);
         decom_req_q <= (decom_req_q & ~take_decom) |
                        (wr_hit && AVS_ADDRESS == REG_REQUEST && AVS_BYTEENABLE[0] &&
                         AVS_WRITEDATA[REQ_DECOM_BIT]);
      end
   end

   // ---------------------------------------------------------------
   // ccm signature
   // ---------------------------------------------------------------
   // address and counter go least significant byte first
   assign nonce = {SOURCE_ADDR[7:0], SOURCE_ADDR[15:8], SOURCE_ADDR[23:16],
                   SOURCE_ADDR[31:24], SOURCE_ADDR[39:32], SOURCE_ADDR[47:40],
                   counter_q[7:0], counter_q[15:8], counter_q[23:16],
                   counter_q[31:24], 24'h00_0000};
   assign AES_KEY = ctrl_q.alt_key ? ALTERNATE_KEY : FACTORY_KEY;

   // cipher requests: b0, then b1 xor x1, then a0 for the mask
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         AES_REQ <= 1'b0;
         AES_IN  <= '0;
      end else if (state_q == ST_IDLE && start && pick == KIND_DATA) begin
         AES_REQ <= 1'b1;
         AES_IN  <= {CCM_B0_FLAGS, nonce, 16'h0000};
      end else if (state_q == ST_MAC0 && AES_DONE) begin
         AES_IN  <= AES_OUT ^ {CCM_ADATA_LEN, DATA_LEN_BYTE, TYPE_BYTE,
                               vendor_q[7:0], vendor_q[15:8], counter_q[7:0],
                               counter_q[15:8], counter_q[23:16], counter_q[31:24],
                               event_q, 40'h00_0000_0000};
      end else if (state_q == ST_MAC1 && AES_DONE) begin
         AES_IN  <= {CCM_A0_FLAGS, nonce, 16'h0000};
      end else if (state_q == ST_MAC2 && AES_DONE) begin
         AES_REQ <= 1'b0;
      end
   end

   // tag from the chain, signature masked by the counter block
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         x1_q  <= '0;
         tag_q <= 32'h0000_0000;
         sig_q <= 32'h0000_0000;
      end else if (AES_DONE) begin
         if (state_q == ST_MAC0) x1_q  <= AES_OUT;
         if (state_q == ST_MAC1) tag_q <= AES_OUT[127:96];
         if (state_q == ST_MAC2) sig_q <= tag_q ^ AES_OUT[127:96];
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   assign done = (state_q == ST_SHOW) && TX_READY && TX_BEAT.last;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         kind_q  <= KIND_DATA;
         event_q <= 8'h00;
         idx_q   <= 5'h00;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               idx_q <= 5'h00;
               if (start) begin
                  kind_q  <= pick;
                  event_q <= sync2_q[7:0];
                  state_q <= (pick == KIND_DATA) ? ST_MAC0 : ST_FILL;
               end
            end
            ST_MAC0: if (AES_DONE) state_q <= ST_MAC1;
            ST_MAC1: if (AES_DONE) state_q <= ST_MAC2;
            ST_MAC2: if (AES_DONE) state_q <= ST_FILL;
            ST_FILL: begin
               idx_q <= idx_q + 5'h01;
               if (idx_q == last_idx) begin
                  idx_q   <= 5'h00;
                  state_q <= ST_LOAD;
               end
            end
            ST_LOAD: state_q <= ST_SHOW;
            ST_SHOW: begin
               if (TX_READY) begin
                  idx_q   <= idx_q + 5'h01;
                  state_q <= TX_BEAT.last ? ST_IDLE : ST_LOAD;
               end
            end
         endcase
      end
   end

   // counter steps once per telegram handed to the radio
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         counter_q <= COUNTER_RESET;
      end else if (done) begin
         counter_q <= counter_q + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // payload assembly
   // ---------------------------------------------------------------
   always_comb begin
      unique case (kind_q)
         KIND_DATA:  last_idx = DATA_LAST;
         KIND_COMM:  last_idx = COMM_LAST;
         default:    last_idx = DECOM_LAST;
      endcase
   end

   // byte for each position of the chosen payload
   always_comb begin
      fill_byte = 8'h00;
      if (kind_q == KIND_DECOM) begin
         fill_byte = DECOM_BYTE;
      end else if (idx_q == 5'h00) begin
         fill_byte = (kind_q == KIND_DATA) ? DATA_LEN_BYTE : COMM_LEN_BYTE;
      end else if (idx_q == 5'h01) begin
         fill_byte = TYPE_BYTE;
      end else if (idx_q < 5'h04) begin
         fill_byte = vendor_q[8*(idx_q-5'h02) +: 8];
      end else if (idx_q < 5'h08) begin
         fill_byte = counter_q[8*(idx_q-5'h04) +: 8];
      end else if (kind_q == KIND_DATA) begin
         if (idx_q == 5'h08) fill_byte = event_q;
         else fill_byte = sig_q[8*(5'h0C-idx_q) +: 8];
      end else if (idx_q < 5'h18) begin
         fill_byte = FACTORY_KEY[8*(5'h17-idx_q) +: 8];
      end else begin
         fill_byte = SOURCE_ADDR[8*(idx_q-5'h18) +: 8];
      end
   end

   taf_payload_ram #(
      .WIDTH (8),
      .DEPTH (32)
   ) u_ram (
      .clk     (CLOCK),
      .wr_en   (state_q == ST_FILL),
      .wr_addr (idx_q),
      .wr_data (fill_byte),
      .rd_addr (idx_q),
      .rd_data (ram_rd)
   );

   // stream out of the buffer
   assign TX_VALID     = (state_q == ST_SHOW);
   assign TX_BEAT.data = ram_rd;
   assign TX_BEAT.last = (idx_q == last_idx);
   assign TX_BEAT.kind = kind_q;
   assign TX_ZGP       = ctrl_q.zgp_mode;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);

   key_select_a: assert property (AES_REQ |-> AES_KEY ==
      (ctrl_q.alt_key ? ALTERNATE_KEY : FACTORY_KEY)) else $error("wrong key");
   nonce_layout_a: assert property (state_q == ST_MAC0 |->
      AES_IN[119:112] == SOURCE_ADDR[7:0] && AES_IN[71:64] == counter_q[7:0]
      && AES_IN[39:16] == 24'h00_0000) else $error("bad nonce");
   counter_step_a: assert property (counter_q != $past(counter_q) |->
      counter_q == $past(counter_q) + 32'h0000_0001 && $past(done))
      else $error("counter jump");
   data_length_a: assert property (TX_VALID && TX_BEAT.last && kind_q == KIND_DATA
      |-> idx_q == 5'h0C) else $error("data length");
   comm_length_a: assert property (TX_VALID && TX_BEAT.last && kind_q == KIND_COMM
      |-> idx_q == 5'h1D) else $error("commission length");
   sig_tail_a: assert property (TX_VALID && kind_q == KIND_DATA && idx_q == SIG_FIRST
      |-> TX_BEAT.data == sig_q[31:24]) else $error("signature placement");
   decom_first_a: assert property (start && ctrl_q.zgp_mode && decom_req_q
      |-> pick == KIND_DECOM ##1 comm_req_q == $past(comm_req_q))
      else $error("decommission priority");
   learn_dir_a: assert property (start && act_lrn && lrn_lat_q && pick == KIND_COMM
      |-> act_dir == lrn_dir_q) else $error("wrong learn direction");
   req_clear_a: assert property (take_comm && !AVS_WRITE |=> !comm_req_q)
      else $error("request kept");

   data_cov: cover property (done && kind_q == KIND_DATA);
   comm_cov: cover property (done && kind_q == KIND_COMM);
   decom_cov: cover property (done && kind_q == KIND_DECOM);
endmodule

/* rtl/taf_payload_ram.sv */
`timescale 1ns/100ps
module taf_payload_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic                     clk,     // system clock
   input  wire logic                     wr_en,   // write strobe
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr, // write address
   input  wire logic [WIDTH-1:0]         wr_data, // write data
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr, // read address
   output      logic [WIDTH-1:0]         rd_data  // registered read data
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] mem_q [DEPTH];  // payload bytes

   // refuse a buffer too small for a commissioning telegram, at elaboration
   if (DEPTH < 30 || WIDTH < 1) begin : g_depth_check
      $error("payload ram too shallow");
   end

   // write port
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // read data from a register
   always_ff @(posedge clk) begin
      rd_data <= mem_q[rd_addr];
   end
endmodule

/* rtl/taf_pkg.sv */
package taf_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [4:0]  REG_CTRL      = 5'h00;   // [0] zgp mode, [1] alternate key
   localparam logic [4:0]  REG_VENDOR    = 5'h04;   // [15:0] vendor identifier
   localparam logic [4:0]  REG_REQUEST   = 5'h08;   // [0] commission, [1] decommission
   localparam logic [4:0]  REG_COUNTER   = 5'h0C;   // telegram counter
   localparam logic [4:0]  REG_STATUS    = 5'h10;   // busy, kind, learn latch
   localparam int          CTRL_ZGP_BIT  = 0;
   localparam int          CTRL_ALT_BIT  = 1;
   localparam int          REQ_COMM_BIT  = 0;
   localparam int          REQ_DECOM_BIT = 1;
   // ---------------------------------------------------------------
   // payload constants
   // ---------------------------------------------------------------
   localparam logic [7:0]  DATA_LEN_BYTE = 8'h0C;   // 12 bytes follow
   localparam logic [7:0]  COMM_LEN_BYTE = 8'h1D;   // 29 bytes follow
   localparam logic [7:0]  TYPE_BYTE     = 8'hFF;   // manufacturer specific data
   localparam logic [7:0]  DECOM_BYTE    = 8'h00;   // single byte decommission body
   localparam logic [4:0]  DATA_LAST     = 5'h0C;   // 13 byte data payload
   localparam logic [4:0]  COMM_LAST     = 5'h1D;   // 30 byte commissioning payload
   localparam logic [4:0]  DECOM_LAST    = 5'h00;   // 1 byte decommission payload
   localparam logic [4:0]  SIG_FIRST     = 5'h09;   // signature follows 9 signed bytes
   // ---------------------------------------------------------------
   // ccm constants: 4 byte tag, 2 byte length field, 9 bytes of header
   // ---------------------------------------------------------------
   localparam logic [7:0]  CCM_B0_FLAGS  = 8'h49;   // adata, m'=1, l'=1
   localparam logic [7:0]  CCM_A0_FLAGS  = 8'h01;   // l'=1
   localparam logic [15:0] CCM_ADATA_LEN = 16'h0009;
   localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {KIND_DATA, KIND_COMM, KIND_DECOM} taf_kind_e;
   typedef struct packed {
      logic [7:0] data;                               // payload byte
      logic       last;                               // final byte of telegram
      taf_kind_e  kind;                               // telegram kind
   } taf_beat_s;
   typedef struct packed {
      logic zgp_mode;                                 // zgp radio format
      logic alt_key;                                  // sign with alternate key
   } taf_ctrl_s;
endpackage

/* verif/taf_radio_rx.sv */
`timescale 1ns/100ps
// radio receiver model: stalls every other cycle, keeps the last telegram,
// counts replayed counters
module taf_radio_rx
   import taf_pkg::*;
(
   input  wire logic      clk,   // system clock
   input  wire taf_beat_s beat,  // payload beat
   input  wire logic      valid, // beat valid
   output      logic      ready  // beat accepted
);
   logic [7:0]  b [0:31];        // bytes of the last telegram
   int          n, len, tel, replay; // index, length, telegrams, replays
   logic [31:0] last_cnt;        // last accepted counter
   logic        have;            // a counter was accepted
   taf_kind_e   kind;            // kind of last telegram
   initial begin
      ready = 0; n = 0; len = 0; tel = 0; replay = 0; have = 0; last_cnt = 0;
   end
   // take a beat, then stall one cycle
   always @(posedge clk) begin
      ready <= valid & ~ready;
      if (valid && ready) begin
         b[n] <= beat.data;
         n    <= n + 1;
         if (beat.last) begin
            len  <= n + 1;
            n    <= 0;
            tel  <= tel + 1;
            kind <= beat.kind;
            // reject equal or lower counters
            if (beat.kind != KIND_DECOM) begin
               if (have && {b[7], b[6], b[5], b[4]} <= last_cnt) replay <= replay + 1;
               else last_cnt <= {b[7], b[6], b[5], b[4]};
               have <= 1;
            end
         end
      end
   end
endmodule

/* verif/telegram_auth_framer_test.sv */
`timescale 1ns/100ps
module telegram_auth_framer_test;
   import taf_pkg::*;
   logic clock, rst, rd, wr, act, dir, learn, wq, valid, ready, zgp, areq, adone;
   logic [4:0] adr;
   logic [31:0] wdat, rdat, got;
   logic [7:0] evt;
   logic [127:0] fk, ak, akey, ain, aout;
   logic [47:0] sa;
   taf_beat_s beat;
   int errors, cmp_count, cyc;
   taf_framer u_taf_framer (.CLOCK(clock), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wq), .ACTUATE_PIN(act), .DIRECTION_PIN(dir), .LEARN_BUTTON_PIN(learn),
      .EVENT_PIN(evt), .FACTORY_KEY(fk), .ALTERNATE_KEY(ak), .SOURCE_ADDR(sa), .AES_REQ(areq),
      .AES_KEY(akey), .AES_IN(ain), .AES_DONE(adone), .AES_OUT(aout), .TX_BEAT(beat),
      .TX_VALID(valid), .TX_READY(ready), .TX_ZGP(zgp));
   taf_radio_rx u_taf_radio_rx (.clk(clock), .beat(beat), .valid(valid), .ready(ready));
   // toy cipher: block xor key, answered every other cycle
   always @(posedge clock) begin
      adone <= areq & ~adone;
      aout  <= ain ^ akey;
   end
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) if (++cyc == 20000) begin errors++; stop_test; end
   function automatic logic [7:0] rb(int i); return u_taf_radio_rx.b[i]; endfunction
   function automatic logic [31:0] w4(int i); return {rb(i+3), rb(i+2), rb(i+1), rb(i)}; endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // avalon access held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      rd <= ~w; wr <= w; adr <= a; wdat <= d;
      @(posedge clock);
      while (wq !== 1'b0) @(posedge clock);
      got = rdat;
      rd <= 0; wr <= 0;
   endtask
   // one harvester actuation, expecting n telegrams
   task automatic actuate(input logic d, input logic l, input int n);
      int t0;
      t0 = u_taf_radio_rx.tel;
      @(posedge clock);
      dir <= d; learn <= l; evt <= evt + 8'h01; act <= 1;
      for (int i = 0; i < 400 && u_taf_radio_rx.tel == t0; i++) @(posedge clock);
      chk(u_taf_radio_rx.tel - t0, n);
      act <= 0;
      repeat (10) @(posedge clock);
   endtask
   task automatic t_data;
      actuate(1, 0, 1);
      chk(u_taf_radio_rx.len, 13);
      chk({rb(1), rb(0)}, 16'hFF0C);
      chk({rb(3), rb(2)}, 16'h0F0F);
      chk(w4(4), 0);
      chk(rb(8), evt);
      chk({rb(9), rb(10), rb(11), rb(12)}, 32'h4809_0CFF ^ fk[127:96]);
      chk(u_taf_radio_rx.kind, KIND_DATA);
      $display("test data done");
   endtask
   task automatic t_cfg;
      bus(1, REG_VENDOR, 32'h0000_1234);
      bus(1, REG_CTRL, 32'h0000_0002);
      actuate(0, 0, 1);
      chk({rb(3), rb(2)}, 16'h1234);
      chk(w4(4), 1);
      chk({rb(9), rb(10), rb(11), rb(12)}, 32'h4809_0CFF ^ ak[127:96]);
      bus(0, REG_COUNTER, 0);
      chk(got, 2);
      $display("test config done");
   endtask
   task automatic t_learn;
      bus(1, REG_CTRL, 32'h0000_0001);
      actuate(1, 1, 1);
      chk(zgp, 1);
      chk(u_taf_radio_rx.kind, KIND_COMM);
      chk(u_taf_radio_rx.len, 30);
      chk({rb(0), rb(1)}, 16'h1DFF);
      for (int i = 0; i < 16; i++) chk(rb(8 + i), fk[127 - 8 * i -: 8]);
      for (int i = 0; i < 6; i++) chk(rb(24 + i), sa[8 * i +: 8]);
      chk(w4(4), 2);
      actuate(0, 1, 0);
      actuate(1, 1, 1);
      chk(w4(4), 3);
      bus(0, REG_STATUS, 0);
      chk(got, 32'h0000_001A);
      $display("test learn done");
   endtask
   task automatic t_req;
      bus(1, REG_REQUEST, 32'h0000_0003);
      actuate(0, 0, 1);
      chk(u_taf_radio_rx.kind, KIND_DECOM);
      chk(u_taf_radio_rx.len, 1);
      chk(rb(0), DECOM_BYTE);
      actuate(1, 0, 1);
      chk(u_taf_radio_rx.kind, KIND_COMM);
      chk(w4(4), 5);
      bus(0, REG_REQUEST, 0);
      chk(got, 0);
      actuate(0, 0, 1);
      chk(u_taf_radio_rx.kind, KIND_DATA);
      bus(0, 5'h14, 0);
      chk(got, 0);
      chk(u_taf_radio_rx.replay, 0);
      $display("test requests done");
   endtask
   task automatic stop_test;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      rst = 1; rd = 0; wr = 0; act = 0; dir = 0; learn = 0; adone = 0; adr = 0; wdat = 0;
      evt = 8'h40; aout = 0; errors = 0; cmp_count = 0; cyc = 0;
      fk = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
      ak = 128'h5A5A_1111_2222_3333_4444_5555_6666_7777;
      sa = 48'h5544_3322_1100;
      repeat (12) @(posedge clock);
      rst <= 0;
      t_data;
      t_cfg;
      t_learn;
      t_req;
      stop_test;
   end
endmodule
